//--- hrp_defs.vh
`ifndef HRP_DEFS_VH
`define HRP_DEFS_VH

// ==========================================================
// Clock and timing
`define HRP_CLK_PERIOD_NS 10
`define HRP_ADDR_SETUP_NS 20
`define HRP_STROBE_MIN_NS 50
`define HRP_RECOVERY_NS 20
`define HRP_CYC_UP(ns) (((ns) + `HRP_CLK_PERIOD_NS - 1) / `HRP_CLK_PERIOD_NS)
`define HRP_ADDR_SETUP_CYC `HRP_CYC_UP(`HRP_ADDR_SETUP_NS)
`define HRP_STROBE_MIN_CYC `HRP_CYC_UP(`HRP_STROBE_MIN_NS)
`define HRP_RECOVERY_CYC `HRP_CYC_UP(`HRP_RECOVERY_NS)
`define HRP_TIMEOUT_CYC 1000

// ==========================================================
// Software register offsets
`define HRP_OFF_CTRL 8'h00
`define HRP_OFF_ADDR 8'h04
`define HRP_OFF_WDATA 8'h08
`define HRP_OFF_CMD 8'h0C
`define HRP_OFF_RDATA 8'h10
`define HRP_OFF_STAT 8'h14
`define HRP_OFF_ISR 8'h18
`define HRP_OFF_IMR 8'h1C

// ==========================================================
// Field positions
`define HRP_CTRL_STYLE 0
`define HRP_CTRL_WIDE 1
`define HRP_CTRL_SWAP 2
`define HRP_CTRL_MUX 3
`define HRP_CTRL_DEVRUN 4
`define HRP_CMD_GO 0
`define HRP_CMD_READ 1
`define HRP_STAT_BUSY 0
`define HRP_STAT_TIMEOUT 1
`define HRP_STAT_IRQ 2
`define HRP_EVT_DONE 0
`define HRP_EVT_TIMEOUT 1
`define HRP_EVT_DEVIRQ 2

// ==========================================================
// Reset values
`define HRP_CTRL_RST 5'h00
`define HRP_IMR_RST 3'h0

`endif

//--- hrp_sync.v
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Two-flop synchroniser for pin inputs
module hrp_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire clk_i,
  input wire nrst_i,
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;
endmodule

`default_nettype wire

//--- hrp_lane_map.v
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Sixteen-bit lane steering, symmetric in both directions
module hrp_lane_map (
  input wire [15:0] word_i,
  input wire swap_i,
  output wire [15:0] word_o
);
  assign word_o = swap_i ? {word_i[7:0], word_i[15:8]} : word_i;
endmodule

`default_nettype wire

//--- hrp_ctrl.v
// Contract
// - Address bits 10:1 pick one 16-bit register or one pair of 8-bit registers.
// - A host with a plain address bus keeps addr_hold_gate high all the time.
// - The host holds chip_select_n low for the whole of each read and write.
// - Strobe style 1 selects data-strobe handshake, 0 selects separate strobes.
// - Separate strobes: read_strobe_n low for reads, store_strobe_n low for writes.
// - Data strobe: data_strobe_n low for both, direction_select high read, low write.
// - Bus width 1 selects a 16-bit path, 0 an 8-bit path.
`include "hrp_defs.vh"
`timescale 1ns/1ns
`default_nettype none

module hrp_ctrl #(
  parameter TIMEOUT_CYC = `HRP_TIMEOUT_CYC
) (
  input wire CLK_I,
  input wire NRST_I,
  input wire [7:0] SW_ADDR_I,
  input wire [31:0] SW_WDATA_I,
  input wire SW_WR_I,
  input wire SW_RD_I,
  output reg [31:0] SW_RDATA_O,
  output wire IRQ_O,
  output wire DEV_RESET_N_O,
  output wire [10:1] REG_SELECT_O,
  output wire ADDR_LSB_O,
  output wire ADDR_HOLD_GATE_O,
  output wire CHIP_SELECT_N_O,
  output wire READ_DATA_STROBE_N_O,
  output wire STORE_DIRECTION_O,
  output wire STROBE_STYLE_O,
  output wire BUS_WIDTH_O,
  input wire [15:0] DATA_I,
  output wire [15:0] DATA_O,
  output wire [15:0] DATA_OE_O,
  input wire READY_N_I,
  input wire IRQ_OUT_N_I
);
  // ==========================================================
  // Constants
  localparam [7:0] SETUP_CYC = `HRP_ADDR_SETUP_CYC;
  localparam [7:0] STROBE_CYC = `HRP_STROBE_MIN_CYC;
  localparam [7:0] RECOV_CYC = `HRP_RECOVERY_CYC;
  localparam [15:0] TO_CYC = TIMEOUT_CYC;

  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_ADDR = 6'h02;
  localparam [5:0] S_LATCH = 6'h04;
  localparam [5:0] S_STRB = 6'h08;
  localparam [5:0] S_RECOV = 6'h10;
  localparam [5:0] S_END = 6'h20;

  // ==========================================================
  // Functions
  function [7:0] byte_of;
    input [15:0] word;
    input hi;
    begin
      byte_of = hi ? word[15:8] : word[7:0];
    end
  endfunction

  function sw_hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      sw_hit = (addr == off);
    end
  endfunction

  // ==========================================================
  // State
  reg [4:0] ctrl_reg;
  reg [9:0] addr_reg;
  reg [15:0] wdata_reg;
  reg [15:0] rdata_reg;
  reg [2:0] isr_reg;
  reg [2:0] imr_reg;
  reg timeout_flag_reg;
  reg [5:0] state_reg;
  reg [7:0] cnt_reg;
  reg [15:0] wait_reg;
  reg dir_read_reg;
  reg byte_hi_reg;
  reg abort_reg;
  reg done_evt_reg;
  reg to_evt_reg;
  reg addr_lsb_reg;
  reg gate_reg;
  reg cs_n_reg;
  reg strobe_on_reg;
  reg [15:0] dout_reg;
  reg [1:0] lane_oe_reg;
  reg [2:0] isr_next;

  wire [17:0] pins_s;
  wire ready_n_s;
  wire irq_n_s;
  wire [15:0] data_s;
  wire [15:0] wdata_mapped;
  wire [15:0] rdata_mapped;
  wire busy;
  wire style_ds;
  wire wide;
  wire swap;
  wire mux;
  wire cmd_go;

  assign busy = (state_reg != S_IDLE);
  assign style_ds = ctrl_reg[`HRP_CTRL_STYLE];
  assign wide = ctrl_reg[`HRP_CTRL_WIDE];
  assign swap = ctrl_reg[`HRP_CTRL_SWAP];
  assign mux = ctrl_reg[`HRP_CTRL_MUX];
  assign cmd_go = SW_WR_I && sw_hit(SW_ADDR_I, `HRP_OFF_CMD) && SW_WDATA_I[`HRP_CMD_GO]
    && !busy;

  // ==========================================================
  // Pin input synchronisers
  hrp_sync #(
    .W(18),
    .RST_VAL({1'b1, 1'b1, 16'h0000})
  ) u_sync (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .d_i({READY_N_I, IRQ_OUT_N_I, DATA_I}),
    .q_o(pins_s)
  );

  assign ready_n_s = pins_s[17];
  assign irq_n_s = pins_s[16];
  assign data_s = pins_s[15:0];

  // ==========================================================
  // Lane steering for 16-bit mode
  hrp_lane_map u_wmap (
    .word_i(wdata_reg),
    .swap_i(swap),
    .word_o(wdata_mapped)
  );

  hrp_lane_map u_rmap (
    .word_i(data_s),
    .swap_i(swap),
    .word_o(rdata_mapped)
  );

  // ==========================================================
  // Software registers
  always @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ctrl_reg <= `HRP_CTRL_RST;
      addr_reg <= 10'h000;
      wdata_reg <= 16'h0000;
      imr_reg <= `HRP_IMR_RST;
    end else if (SW_WR_I && !busy) begin
      if (sw_hit(SW_ADDR_I, `HRP_OFF_CTRL)) begin
        ctrl_reg <= SW_WDATA_I[4:0];
      end
      if (sw_hit(SW_ADDR_I, `HRP_OFF_ADDR)) begin
        addr_reg <= SW_WDATA_I[10:1];
      end
      if (sw_hit(SW_ADDR_I, `HRP_OFF_WDATA)) begin
        wdata_reg <= SW_WDATA_I[15:0];
      end
      if (sw_hit(SW_ADDR_I, `HRP_OFF_IMR)) begin
        imr_reg <= SW_WDATA_I[2:0];
      end
    end else if (SW_WR_I && sw_hit(SW_ADDR_I, `HRP_OFF_IMR)) begin
      imr_reg <= SW_WDATA_I[2:0];
    end
  end

  // Sticky events, set wins over write-one-clear
  always @* begin
    isr_next = isr_reg;
    if (SW_WR_I && sw_hit(SW_ADDR_I, `HRP_OFF_ISR)) begin
      isr_next = isr_next & ~SW_WDATA_I[2:0];
    end
    if (done_evt_reg) begin
      isr_next[`HRP_EVT_DONE] = 1'b1;
    end
    if (to_evt_reg) begin
      isr_next[`HRP_EVT_TIMEOUT] = 1'b1;
    end
    if (!irq_n_s && DEV_RESET_N_O) begin
      isr_next[`HRP_EVT_DEVIRQ] = 1'b1;
    end
  end

  always @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      isr_reg <= 3'h0;
    end else begin
      isr_reg <= isr_next;
    end
  end

  assign IRQ_O = |(isr_reg & imr_reg);

  // Read data one cycle after the strobe
  always @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      SW_RDATA_O <= 32'h00000000;
    end else if (SW_RD_I) begin
      case (SW_ADDR_I)
        `HRP_OFF_CTRL: SW_RDATA_O <= {27'h0000000, ctrl_reg};
        `HRP_OFF_ADDR: SW_RDATA_O <= {21'h000000, addr_reg, 1'b0};
        `HRP_OFF_WDATA: SW_RDATA_O <= {16'h0000, wdata_reg};
        `HRP_OFF_RDATA: SW_RDATA_O <= {16'h0000, rdata_reg};
        `HRP_OFF_STAT: SW_RDATA_O <= {29'h00000000, !irq_n_s, timeout_flag_reg, busy};
        `HRP_OFF_ISR: SW_RDATA_O <= {29'h00000000, isr_reg};
        `HRP_OFF_IMR: SW_RDATA_O <= {29'h00000000, imr_reg};
        default: SW_RDATA_O <= 32'h00000000;
      endcase
    end else begin
      SW_RDATA_O <= 32'h00000000;
    end
  end

  // ==========================================================
  // Device access sequencer
  always @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_reg <= S_IDLE;
      cnt_reg <= 8'h00;
      wait_reg <= 16'h0000;
      dir_read_reg <= 1'b0;
      byte_hi_reg <= 1'b0;
      abort_reg <= 1'b0;
      done_evt_reg <= 1'b0;
      to_evt_reg <= 1'b0;
      timeout_flag_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      addr_lsb_reg <= 1'b0;
      gate_reg <= 1'b1;
      cs_n_reg <= 1'b1;
      strobe_on_reg <= 1'b0;
      dout_reg <= 16'h0000;
      lane_oe_reg <= 2'b00;
    end else begin
      done_evt_reg <= 1'b0;
      to_evt_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          gate_reg <= 1'b1;
          cs_n_reg <= 1'b1;
          strobe_on_reg <= 1'b0;
          lane_oe_reg <= 2'b00;
          if (cmd_go) begin
            dir_read_reg <= SW_WDATA_I[`HRP_CMD_READ];
            byte_hi_reg <= 1'b0;
            abort_reg <= 1'b0;
            timeout_flag_reg <= 1'b0;
            cnt_reg <= SETUP_CYC;
            state_reg <= S_ADDR;
          end
        end
        S_ADDR: begin
          cs_n_reg <= 1'b0;
          gate_reg <= 1'b1;
          addr_lsb_reg <= wide ? swap : byte_hi_reg;
          if (!dir_read_reg) begin
            if (wide) begin
              dout_reg <= wdata_mapped;
              lane_oe_reg <= 2'b11;
            end else begin
              dout_reg <= {8'h00, byte_of(wdata_reg, byte_hi_reg)};
              lane_oe_reg <= 2'b01;
            end
          end
          if (cnt_reg <= 8'h01) begin
            if (mux) begin
              gate_reg <= 1'b0;
              cnt_reg <= SETUP_CYC;
              state_reg <= S_LATCH;
            end else begin
              strobe_on_reg <= 1'b1;
              cnt_reg <= STROBE_CYC;
              wait_reg <= 16'h0000;
              state_reg <= S_STRB;
            end
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        S_LATCH: begin
          if (cnt_reg <= 8'h01) begin
            strobe_on_reg <= 1'b1;
            cnt_reg <= STROBE_CYC;
            wait_reg <= 16'h0000;
            state_reg <= S_STRB;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        S_STRB: begin
          wait_reg <= wait_reg + 16'h0001;
          if (cnt_reg > 8'h01) begin
            cnt_reg <= cnt_reg - 8'h01;
          end
          if (cnt_reg <= 8'h01 && !ready_n_s) begin
            if (dir_read_reg) begin
              if (wide) begin
                rdata_reg <= rdata_mapped;
              end else if (byte_hi_reg) begin
                rdata_reg[15:8] <= data_s[7:0];
              end else begin
                rdata_reg[7:0] <= data_s[7:0];
              end
            end
            strobe_on_reg <= 1'b0;
            cnt_reg <= RECOV_CYC;
            state_reg <= S_RECOV;
          end else if (wait_reg >= TO_CYC) begin
            strobe_on_reg <= 1'b0;
            abort_reg <= 1'b1;
            timeout_flag_reg <= 1'b1;
            to_evt_reg <= 1'b1;
            cnt_reg <= RECOV_CYC;
            state_reg <= S_RECOV;
          end
        end
        S_RECOV: begin
          if (cnt_reg <= 8'h01) begin
            lane_oe_reg <= 2'b00;
            cs_n_reg <= 1'b1;
            state_reg <= S_END;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        S_END: begin
          gate_reg <= 1'b1;
          if (!wide && !byte_hi_reg && !abort_reg) begin
            byte_hi_reg <= 1'b1;
            cnt_reg <= SETUP_CYC;
            state_reg <= S_ADDR;
          end else begin
            done_evt_reg <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Device pins
  assign DEV_RESET_N_O = ctrl_reg[`HRP_CTRL_DEVRUN];
  assign REG_SELECT_O = addr_reg;
  assign ADDR_LSB_O = addr_lsb_reg;
  assign ADDR_HOLD_GATE_O = gate_reg;
  assign CHIP_SELECT_N_O = cs_n_reg;
  assign STROBE_STYLE_O = style_ds;
  assign BUS_WIDTH_O = wide;
  // Separate style: read strobe here; data-strobe style: common strobe
  assign READ_DATA_STROBE_N_O = !(strobe_on_reg && (style_ds || dir_read_reg));
  // Separate style: store strobe; data-strobe style: direction, high for read
  assign STORE_DIRECTION_O = style_ds ? dir_read_reg
    : !(strobe_on_reg && !dir_read_reg);
  assign DATA_O = dout_reg;
  assign DATA_OE_O = {{8{lane_oe_reg[1]}}, {8{lane_oe_reg[0]}}};

endmodule

`default_nettype wire

//--- hrp_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// Register device at the far side of the host port
module hrp_dev_model #(
  parameter int RDY_DLY = 3
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [10:1] sel_i,
  input wire logic lsb_i,
  input wire logic gate_i,
  input wire logic cs_n_i,
  input wire logic rd_ds_n_i,
  input wire logic wr_dir_i,
  input wire logic style_i,
  input wire logic wide_i,
  input wire logic [15:0] host_d_i,
  input wire logic [15:0] host_oe_i,
  input wire logic stall_i,
  input wire logic event_i,
  output wire logic [15:0] bus_o,
  output wire logic rdy_n_o,
  output wire logic irq_n_o
);
  logic [15:0] mem [0:1023];
  logic [10:0] adr;
  logic [15:0] drv;
  logic [15:0] dev_oe;
  logic rd_act;
  logic wr_act;
  int cnt = 0;
  // Address latch, open while the gate is high
  always_latch if (gate_i) adr = {sel_i, lsb_i};
  assign rd_act = rst_n_i && !cs_n_i && !rd_ds_n_i && (!style_i || wr_dir_i);
  assign wr_act = rst_n_i && !cs_n_i && (style_i ? !rd_ds_n_i && !wr_dir_i : !wr_dir_i);
  // Write taken as the strobe ends
  always @(negedge wr_act or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem[0] <= 16'h0000;
    end else if (!wide_i) begin
      if (adr[0]) mem[adr[10:1]][15:8] <= host_d_i[7:0];
      else mem[adr[10:1]][7:0] <= host_d_i[7:0];
    end else begin
      mem[adr[10:1]] <= adr[0] ? {host_d_i[7:0], host_d_i[15:8]} : host_d_i;
    end
  end
  assign drv = adr[0] ? {mem[adr[10:1]][7:0], mem[adr[10:1]][15:8]} : mem[adr[10:1]];
  assign dev_oe = !rd_act ? 16'h0000 : wide_i ? 16'hFFFF : 16'h00FF;
  // Released lines sit at their pull-up level
  assign bus_o = (host_d_i & host_oe_i) | (~host_oe_i & ~dev_oe) | (~host_oe_i & dev_oe & drv);
  always @(posedge clk_i) cnt <= (rd_act || wr_act) ? cnt + 1 : 0;
  assign rdy_n_o = !((rd_act || wr_act) && cnt >= RDY_DLY && !stall_i);
  assign irq_n_o = !(rst_n_i && mem[0][0] && event_i);
endmodule
`default_nettype wire

//--- hrp_ctrl_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// Pin checks of the host port controller
module hrp_ctrl_sva (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic IRQ_O,
  input wire logic [10:1] REG_SELECT_O,
  input wire logic ADDR_LSB_O,
  input wire logic ADDR_HOLD_GATE_O,
  input wire logic CHIP_SELECT_N_O,
  input wire logic READ_DATA_STROBE_N_O,
  input wire logic STORE_DIRECTION_O,
  input wire logic STROBE_STYLE_O,
  input wire logic BUS_WIDTH_O,
  input wire logic [15:0] DATA_O,
  input wire logic [15:0] DATA_OE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  wire rd_act = !READ_DATA_STROBE_N_O && (!STROBE_STYLE_O || STORE_DIRECTION_O);
  wire wr_sep = !STROBE_STYLE_O && !STORE_DIRECTION_O;
  narrow_lanes_a: assert property (!BUS_WIDTH_O |-> DATA_OE_O[15:8] == 8'h00)
    else $error("upper lanes driven");
  bus_release_a: assert property (CHIP_SELECT_N_O |-> DATA_OE_O == 16'h0000)
    else $error("bus driven unselected");
  read_turn_a: assert property (rd_act |-> DATA_OE_O == 16'h0000)
    else $error("bus driven in read");
  strobe_cs_a: assert property (!READ_DATA_STROBE_N_O || wr_sep |-> !CHIP_SELECT_N_O)
    else $error("strobe without select");
  sep_strobes_a: assert property (!STROBE_STYLE_O |-> READ_DATA_STROBE_N_O || STORE_DIRECTION_O)
    else $error("both strobes low");
  strobe_width_a: assert property ($fell(READ_DATA_STROBE_N_O) |-> !READ_DATA_STROBE_N_O [*5])
    else $error("strobe too short");
  addr_hold_a: assert property (!ADDR_HOLD_GATE_O && $past(!ADDR_HOLD_GATE_O) |->
    $stable(REG_SELECT_O) && $stable(ADDR_LSB_O)) else $error("address moved");
  cycle_mode_a: assert property (!CHIP_SELECT_N_O && $past(!CHIP_SELECT_N_O) |->
    $stable({REG_SELECT_O, BUS_WIDTH_O, STROBE_STYLE_O})) else $error("mode moved");
  wdata_hold_a: assert property (!CHIP_SELECT_N_O && $past(!CHIP_SELECT_N_O) &&
    DATA_OE_O != 16'h0000 |-> $stable(DATA_O)) else $error("write data moved");
  cover property ($fell(ADDR_HOLD_GATE_O));
  cover property (!BUS_WIDTH_O && rd_act);
  cover property (STROBE_STYLE_O && rd_act);
  cover property (IRQ_O);
endmodule
bind hrp_ctrl hrp_ctrl_sva u_sva (.*);
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct packed {logic [4:0] c; logic [10:0] a; logic [15:0] d;} hrp_row_t;
  hrp_row_t rows [0:7] = '{{5'h10, 11'h002, 16'hA55A}, {5'h11, 11'h7FE, 16'h1234},
    {5'h12, 11'h004, 16'hBEEF}, {5'h16, 11'h006, 16'hC3A1}, {5'h17, 11'h400, 16'h0F0E},
    {5'h1A, 11'h008, 16'h8001}, {5'h19, 11'h00A, 16'h7E81}, {5'h1F, 11'h3FE, 16'h5AA5}};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] sw_addr = 8'h00;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic stall = 1'b0;
  logic evt = 1'b0;
  logic [31:0] v, rdata;
  logic irq, dev_rst_n, lsb, gate, cs_n, rds_n, stdir, style, wide, rdy_n, irq_n;
  logic [10:1] sel;
  logic [15:0] dout, doe, bus;
  int n_errors = 0;
  int n_compared = 0;
  initial forever #5 clk = ~clk;
  hrp_ctrl #(.TIMEOUT_CYC(20)) uut (.CLK_I(clk), .NRST_I(nrst), .SW_ADDR_I(sw_addr),
    .SW_WDATA_I(sw_wdata), .SW_WR_I(sw_wr), .SW_RD_I(sw_rd), .SW_RDATA_O(rdata),
    .IRQ_O(irq), .DEV_RESET_N_O(dev_rst_n), .REG_SELECT_O(sel), .ADDR_LSB_O(lsb),
    .ADDR_HOLD_GATE_O(gate), .CHIP_SELECT_N_O(cs_n), .READ_DATA_STROBE_N_O(rds_n),
    .STORE_DIRECTION_O(stdir), .STROBE_STYLE_O(style), .BUS_WIDTH_O(wide), .DATA_I(bus),
    .DATA_O(dout), .DATA_OE_O(doe), .READY_N_I(rdy_n), .IRQ_OUT_N_I(irq_n));
  hrp_dev_model dev (.clk_i(clk), .rst_n_i(dev_rst_n), .sel_i(sel), .lsb_i(lsb),
    .gate_i(gate), .cs_n_i(cs_n), .rd_ds_n_i(rds_n), .wr_dir_i(stdir), .style_i(style),
    .wide_i(wide), .host_d_i(dout), .host_oe_i(doe), .stall_i(stall), .event_i(evt),
    .bus_o(bus), .rdy_n_o(rdy_n), .irq_n_o(irq_n));
  // ====
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic sw_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= w;
    sw_rd <= !w;
    @(posedge clk);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask
  task automatic access(input logic [4:0] c, input logic [10:0] a, input logic [15:0] d,
                        input logic r);
    sw_cycle(1'b1, 8'h00, {27'h0, c});
    sw_cycle(1'b1, 8'h04, {21'h0, a});
    sw_cycle(1'b1, 8'h08, {16'h0, d});
    sw_cycle(1'b1, 8'h0C, {30'h0, r, 1'b1});
    repeat (2) @(posedge clk);
    for (int i = 0; i < 300; i++) begin
      sw_cycle(1'b0, 8'h14, 32'h0);
      if (v[0] === 1'b0) break;
    end
    chk({31'h0, v[0]}, 32'h0);
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ====
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      access(rows[i].c, rows[i].a, rows[i].d, 1'b0);
      chk({16'h0, dev.mem[rows[i].a[10:1]]}, {16'h0, rows[i].d});
      access(rows[i].c, rows[i].a, 16'h0, 1'b1);
      sw_cycle(1'b0, 8'h10, 32'h0);
      chk(v, {16'h0, rows[i].d});
    end
    sw_cycle(1'b1, 8'h18, 32'h7);
    evt <= 1'b1;
    repeat (8) @(posedge clk);
    sw_cycle(1'b0, 8'h18, 32'h0);
    chk(v, 32'h0);
    access(5'h12, 11'h000, 16'h0001, 1'b0);
    repeat (8) @(posedge clk);
    sw_cycle(1'b0, 8'h18, 32'h0);
    chk(v, 32'h5);
    sw_cycle(1'b1, 8'h1C, 32'h4);
    chk({31'h0, irq}, 32'h1);
    sw_cycle(1'b1, 8'h1C, 32'h0);
    chk({31'h0, irq}, 32'h0);
    evt <= 1'b0;
    repeat (8) @(posedge clk);
    sw_cycle(1'b1, 8'h18, 32'h7);
    sw_cycle(1'b0, 8'h18, 32'h0);
    chk(v, 32'h0);
    stall <= 1'b1;
    access(5'h12, 11'h00C, 16'h0, 1'b1);
    sw_cycle(1'b0, 8'h14, 32'h0);
    chk({31'h0, v[1]}, 32'h1);
    sw_cycle(1'b0, 8'h18, 32'h0);
    chk({31'h0, v[1]}, 32'h1);
    stall <= 1'b0;
    access(5'h12, 11'h00C, 16'h6C3B, 1'b0);
    chk({16'h0, dev.mem[6]}, 32'h6C3B);
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    sw_cycle(1'b0, 8'h00, 32'h0);
    chk(v, 32'h0);
    sw_cycle(1'b0, 8'h20, 32'h0);
    chk(v, 32'h0);
    sw_cycle(1'b0, 8'h14, 32'h0);
    chk(v, 32'h0);
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test;
  end
endmodule
`default_nettype wire
